// >>> sbt_ccp_model.sv
// sbt_ccp_model: compare unit raising the special event trigger
`timescale 1ns/1ps
module sbt_ccp_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// compare setup
	input  wire logic [15:0] compare_value_pair,
	input  wire logic        match_enable,
	input  wire logic        force_trigger,
	// timer side
	input  wire logic [15:0] timebase,
	input  wire logic        timebase_is_this,
	output logic             special_event_trigger
);
	logic hit;
	logic hit_q;
	logic pulse_q;

	// one pulse per match, so the pair acts as period
	assign hit = match_enable && timebase_is_this && timebase == compare_value_pair;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hit_q   <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			hit_q   <= hit;
			pulse_q <= hit && !hit_q;
		end
	end
	assign special_event_trigger = pulse_q || force_trigger;
endmodule

// >>> sbt_pkg.sv
// sbt_pkg: constants and types of the sixteen-bit timer with trigger reset
package sbt_pkg;

	// ----------------------------------------------------------------
	// register map (byte data, one register per address)
	// ----------------------------------------------------------------
	localparam int          SBT_AW          = 3;
	localparam logic [2:0]  SBT_OFS_CTRL    = 3'h0; // timer_three_control
	localparam logic [2:0]  SBT_OFS_LOW     = 3'h1; // count_low_byte
	localparam logic [2:0]  SBT_OFS_HIGH    = 3'h2; // count_high_byte
	localparam logic [2:0]  SBT_OFS_FLAGS   = 3'h3; // peripheral_flags_two
	localparam logic [2:0]  SBT_OFS_ENABLES = 3'h4; // peripheral_enables_two

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SBT_BIT_RUN     = 0; // counter_run_enable
	localparam int SBT_BIT_CS      = 1; // clock_source_select
	localparam int SBT_BIT_SYNC    = 2; // external_clock_sync_bypass
	localparam int SBT_BIT_TBSEL   = 3; // capture_compare_timebase_select
	localparam int SBT_BIT_PS_LO   = 4; // prescale_select_lo
	localparam int SBT_BIT_PS_HI   = 5; // prescale_select_hi
	localparam int SBT_BIT_ATOMIC_SIXTEEN_BIT_ACCESS    = 7; // atomic_sixteen_bit_access
	localparam int SBT_BIT_OVF     = 1; // overflow_flag / overflow_irq_enable

	// ----------------------------------------------------------------
	// reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0]  SBT_CTRL_RST    = 8'h00;
	localparam logic [7:0]  SBT_CTRL_MASK   = 8'hbf; // bit 6 unimplemented
	localparam logic [7:0]  SBT_OVF_MASK    = 8'h02; // only bit 1 lives
	localparam logic [15:0] SBT_COUNT_RST   = 16'h0000;
	localparam logic [15:0] SBT_COUNT_MAX   = 16'hffff;
	localparam logic [3:0]  SBT_MODE_SPEVT  = 4'hb; // compare, special event

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          SBT_CLK_MHZ     = 40;
	localparam int          SBT_INSTR_DIV   = 4;  // clocks per instruction cycle
	localparam logic [1:0]  SBT_INSTR_LAST  = 2'(SBT_INSTR_DIV - 1);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       atomic_sixteen_bit_access;
		logic       unused6;
		logic       prescale_select_hi;
		logic       prescale_select_lo;
		logic       capture_compare_timebase_select;
		logic       external_clock_sync_bypass;
		logic       clock_source_select;
		logic       counter_run_enable;
	} sbt_ctrl_t;

	typedef struct packed {
		logic [1:0] oscillator_pin_directions; // 1 = input
		logic [1:0] port_out;
		logic [1:0] pin_in;
	} sbt_pins_in_t;

	typedef struct packed {
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic [1:0] port_read;
	} sbt_pins_out_t;

endpackage

// >>> sbt_timer.sv
// sbt_timer: sixteen-bit timer/counter with prescaler, trigger reset and registers
//
// Function
// - 16-bit count, both bytes read and written
// - counts up, wraps, sets overflow flag bit 1
// - overflow interrupt only when enable bit set
// - instruction cycle or external rising edges
// - timer, synchronized and unsynchronized counter modes
// - prescale codes 11/10/01 divide 8/4/2
// - bit 3 selects this timer as timebase
// - bit 0 runs, clear holds count
// - oscillator enabled forces pins input, read zero
// - sibling bit 3 enables secondary oscillator source
// - special event trigger in mode 1011 clears
// - trigger clear never sets overflow flag
// - software write beats trigger reset
// - compare pair acts as period
// - reset loads control zero, bit 6 zero
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module sbt_timer
	import sbt_pkg::*;
(
	// clock, reset, enable
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	// register port
	input  wire logic [SBT_AW-1:0]     reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	// clock sources (asynchronous)
	input  wire logic                  ext_clk_pin,
	input  wire logic                  osc_clk,
	// sibling timer and compare unit
	input  wire logic                  secondary_osc_enable,
	input  wire logic [15:0]           sibling_count,
	input  wire logic [3:0]            capture_compare_mode_field,
	input  wire logic                  special_event_trigger,
	output logic      [15:0]           ccp_timebase,
	output logic                       ccp_timebase_is_this,
	// oscillator pins
	input  wire sbt_pins_in_t          pins_in,
	output sbt_pins_out_t              pins_out,
	// interrupt
	output logic                       irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	sbt_ctrl_t     ctrl_q;
	logic [15:0]   count_q;
	logic [7:0]    hbuf_q;
	logic          flag_q;
	logic          enable_q;
	logic [1:0]    phase_q;
	logic [2:0]    ps_cnt_q;
	logic          ext_s1_q;
	logic          ext_s2_q;
	logic          ext_s3_q;
	logic          ext_s4_q;
	logic          pend_q;
	logic          osc_s1_q;
	logic          osc_s2_q;
	logic [7:0]    rdata_q;
	logic [15:0]   tb_q;
	logic          tb_sel_q;
	sbt_pins_out_t pins_q;
	logic          irq_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic       wr_ctrl;
	logic       wr_low;
	logic       wr_high;
	logic       wr_flags;
	logic       wr_en;
	logic       rd_low;
	logic       int_tick;
	logic       ext_sel;
	logic       ext_edge_sync;
	logic       ext_edge_raw;
	logic       ext_sync_mode;
	logic       src_tick;
	logic [2:0] ps_last;
	logic       pre_tick;
	logic       inc;
	logic       trig_clr;
	logic       wrap;
	logic       count_wr;

	// register strobes
	assign wr_ctrl  = reg_wr && (reg_addr == SBT_OFS_CTRL);
	assign wr_low   = reg_wr && (reg_addr == SBT_OFS_LOW);
	assign wr_high  = reg_wr && (reg_addr == SBT_OFS_HIGH);
	assign wr_flags = reg_wr && (reg_addr == SBT_OFS_FLAGS);
	assign wr_en    = reg_wr && (reg_addr == SBT_OFS_ENABLES);
	assign rd_low   = reg_rd && (reg_addr == SBT_OFS_LOW);
	assign count_wr = wr_low || (wr_high && !ctrl_q.atomic_sixteen_bit_access);

	// ----------------------------------------------------------------
	// clock sources
	// ----------------------------------------------------------------

	// instruction cycle: one tick per four system clocks
	// free-running, so a restart may begin mid-cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 2'h0;
		end else if (ce) begin
			phase_q <= (phase_q == SBT_INSTR_LAST) ? 2'h0 : phase_q + 2'h1;
		end
	end
	assign int_tick = (phase_q == SBT_INSTR_LAST);

	// two-stage synchronisers for both external sources
	// only the second stage feeds logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
		end else if (ce) begin
			ext_s1_q <= ext_clk_pin;
			ext_s2_q <= ext_s1_q;
			osc_s1_q <= osc_clk;
			osc_s2_q <= osc_s1_q;
		end
	end

	// secondary oscillator replaces the pin when enabled
	// switching source mid-run may count one stray edge
	assign ext_sel = secondary_osc_enable ? osc_s2_q : ext_s2_q;

	// edge history: s3 for the raw edge, s4 aligns the synchronised edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s3_q <= 1'b0;
			ext_s4_q <= 1'b0;
		end else if (ce) begin
			ext_s3_q <= ext_sel;
			ext_s4_q <= ext_s3_q;
		end
	end
	assign ext_edge_raw  = ext_sel && !ext_s3_q;
	assign ext_edge_sync = ext_s3_q && !ext_s4_q;

	// synchronised edge waits here for the next instruction tick
	// edges faster than the tick rate may merge into one count
	assign ext_sync_mode = ctrl_q.counter_run_enable && ctrl_q.clock_source_select
	                       && !ctrl_q.external_clock_sync_bypass;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else if (ce) begin
			if (!ext_sync_mode || int_tick) begin
				pend_q <= 1'b0;
			end else if (ext_edge_sync) begin
				pend_q <= 1'b1;
			end
		end
	end

	// mode select: internal, synchronised or bypassed external edge
	always_comb begin
		if (!ctrl_q.clock_source_select) begin
			src_tick = int_tick;
		end else if (ctrl_q.external_clock_sync_bypass) begin
			src_tick = ext_edge_raw;
		end else begin
			src_tick = (ext_edge_sync || pend_q) && int_tick;
		end
	end

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------

	// last prescaler count per code
	always_comb begin
		unique case ({ctrl_q.prescale_select_hi, ctrl_q.prescale_select_lo})
			2'b11:   ps_last = 3'h7;
			2'b10:   ps_last = 3'h3;
			2'b01:   ps_last = 3'h1;
			default: ps_last = 3'h0;
		endcase
	end
	assign pre_tick = ctrl_q.counter_run_enable && src_tick && (ps_cnt_q >= ps_last);

	// prescaler counter, held while stopped
	// low write restarts it: no partial period inherited
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ps_cnt_q <= 3'h0;
		end else if (ce) begin
			if (wr_low) begin
				ps_cnt_q <= 3'h0;
			end else if (ctrl_q.counter_run_enable && src_tick) begin
				ps_cnt_q <= (ps_cnt_q >= ps_last) ? 3'h0 : ps_cnt_q + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------

	// trigger reset from compare unit in special event mode
	// clear applies in every clock mode, unsynchronised included
	assign trig_clr = special_event_trigger && (capture_compare_mode_field == SBT_MODE_SPEVT);
	assign inc      = pre_tick && !count_wr && !trig_clr;
	assign wrap     = inc && (count_q == SBT_COUNT_MAX);

	// count: writes first, then trigger clear, then increment
	// a coinciding write beats the trigger clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= SBT_COUNT_RST;
		end else if (ce) begin
			if (wr_low) begin
				if (ctrl_q.atomic_sixteen_bit_access) begin
					count_q <= {hbuf_q, reg_wdata};
				end else begin
					count_q[7:0] <= reg_wdata;
				end
			end else if (wr_high && !ctrl_q.atomic_sixteen_bit_access) begin
				count_q[15:8] <= reg_wdata;
			end else if (trig_clr) begin
				count_q <= SBT_COUNT_RST;
			end else if (inc) begin
				count_q <= count_q + 16'h0001;
			end
		end
	end

	// high-byte buffer for atomic access
	// low read snapshots high byte for a consistent pair
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hbuf_q <= 8'h00;
		end else if (ce) begin
			if (wr_high && ctrl_q.atomic_sixteen_bit_access) begin
				hbuf_q <= reg_wdata;
			end else if (rd_low && ctrl_q.atomic_sixteen_bit_access) begin
				hbuf_q <= count_q[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// control and interrupt registers
	// ----------------------------------------------------------------

	// control register, bit 6 held at zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= sbt_ctrl_t'(SBT_CTRL_RST);
		end else if (ce && wr_ctrl) begin
			ctrl_q <= sbt_ctrl_t'(reg_wdata & SBT_CTRL_MASK);
		end
	end

	// sticky overflow flag, write one clears, set wins
	// wrap beside a clear keeps the flag: no overflow lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else if (ce) begin
			if (wrap) begin
				flag_q <= 1'b1;
			end else if (wr_flags && reg_wdata[SBT_BIT_OVF]) begin
				flag_q <= 1'b0;
			end
		end
	end

	// overflow enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_q <= 1'b0;
		end else if (ce && wr_en) begin
			enable_q <= reg_wdata[SBT_BIT_OVF];
		end
	end

	// level interrupt while flag and enable are both set
	// registered, so irq lags the flag by one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= flag_q && enable_q;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// answer stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= 8'h00;
			if (reg_rd) begin
				unique case (reg_addr)
					SBT_OFS_CTRL:    rdata_q <= 8'(ctrl_q) & SBT_CTRL_MASK;
					SBT_OFS_LOW:     rdata_q <= count_q[7:0];
					SBT_OFS_HIGH:    rdata_q <= ctrl_q.atomic_sixteen_bit_access ? hbuf_q
					                                                               : count_q[15:8];
					SBT_OFS_FLAGS:   rdata_q <= {6'h00, flag_q, 1'b0};
					SBT_OFS_ENABLES: rdata_q <= {6'h00, enable_q, 1'b0};
					default:         rdata_q <= 8'h00; // unmapped reads zero
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// compare unit timebase
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tb_q     <= 16'h0000;
			tb_sel_q <= 1'b0;
		end else if (ce) begin
			tb_q     <= ctrl_q.capture_compare_timebase_select ? count_q : sibling_count;
			tb_sel_q <= ctrl_q.capture_compare_timebase_select;
		end
	end

	// ----------------------------------------------------------------
	// oscillator pins
	// ----------------------------------------------------------------

	// oscillator enable overrides direction and reads zero
	// port data passes through; only direction and read back change
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_q <= '0;
		end else if (ce) begin
			pins_q.pin_out <= pins_in.port_out;
			if (secondary_osc_enable) begin
				pins_q.pin_oe    <= 2'h0;
				pins_q.port_read <= 2'h0;
			end else begin
				pins_q.pin_oe    <= ~pins_in.oscillator_pin_directions;
				pins_q.port_read <= pins_in.pin_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata            = rdata_q;
	assign ccp_timebase         = tb_q;
	assign ccp_timebase_is_this = tb_sel_q;
	assign pins_out             = pins_q;
	assign irq                  = irq_q;

endmodule

// >>> sbt_timer_checker.sv
// sbt_timer_checker: port assertions of the timer
`timescale 1ns/1ps
module sbt_timer_checker
	import sbt_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// register port
	input wire logic [SBT_AW-1:0] reg_addr,
	input wire logic [7:0]        reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_rdata,
	// compare side, pins, interrupt
	input wire logic [15:0]       sibling_count,
	input wire logic [3:0]        capture_compare_mode_field,
	input wire logic              special_event_trigger,
	input wire logic [15:0]       ccp_timebase,
	input wire logic              ccp_timebase_is_this,
	input wire logic              secondary_osc_enable,
	input wire sbt_pins_out_t     pins_out,
	input wire logic              irq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [7:0] ctrl_q;

	// ------------------------------------------------
	// expected control contents
	// ------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ctrl_q <= SBT_CTRL_RST;
		else if (reg_wr && reg_addr == SBT_OFS_CTRL)
			ctrl_q <= reg_wdata & SBT_CTRL_MASK;
	end

	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside answer");
	a_ctrl_readback: assert property (reg_rd && reg_addr == SBT_OFS_CTRL |=> reg_rdata == ctrl_q)
		else $error("control read differs");
	a_osc_inputs: assert property (secondary_osc_enable |=> pins_out.pin_oe == 2'h0 && pins_out.port_read == 2'h0)
		else $error("oscillator pins not inputs");
	a_sibling_base: assert property ($past(rst_n) && !ccp_timebase_is_this |-> ccp_timebase == $past(sibling_count))
		else $error("sibling time base wrong");
	a_count_step: assert property ($past(rst_n, 3) && ccp_timebase_is_this && $past(ccp_timebase_is_this)
		&& !$past(reg_wr, 2) && !$past(special_event_trigger, 2)
		|-> ccp_timebase == $past(ccp_timebase) || ccp_timebase == 16'($past(ccp_timebase) + 16'h0001))
		else $error("count moved other than by one");
	a_trig_clear: assert property (special_event_trigger && capture_compare_mode_field == SBT_MODE_SPEVT && !reg_wr
		&& !$past(reg_wr) && ccp_timebase_is_this |=> ##1 ccp_timebase == 16'h0000)
		else $error("trigger did not clear count");
	a_write_wins: assert property (special_event_trigger && reg_wr && reg_addr == SBT_OFS_LOW && !$past(reg_wr)
		&& ccp_timebase_is_this |=> ##1 ccp_timebase[7:0] == $past(reg_wdata, 2))
		else $error("trigger beat the write");
	a_irq_masked: assert property (reg_wr && reg_addr == SBT_OFS_ENABLES && !reg_wdata[SBT_BIT_OVF] |=> ##1 !irq)
		else $error("irq while disabled");

	c_trigger: cover property (special_event_trigger && capture_compare_mode_field == SBT_MODE_SPEVT);
	c_irq: cover property ($rose(irq));
	c_osc: cover property (secondary_osc_enable && reg_rd);
endmodule

bind sbt_timer sbt_timer_checker u_sbt_timer_checker (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sibling_count(sibling_count),
	.capture_compare_mode_field(capture_compare_mode_field), .special_event_trigger(special_event_trigger),
	.ccp_timebase(ccp_timebase), .ccp_timebase_is_this(ccp_timebase_is_this),
	.secondary_osc_enable(secondary_osc_enable), .pins_out(pins_out), .irq(irq)
);

// >>> sbt_timer_test.sv
// sbt_timer_test: self-checking bench of the timer
`timescale 1ns/1ps
module sbt_timer_test
	import sbt_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ext_pin = 1'b0;
	logic osc_clk = 1'b0;
	logic osc_en = 1'b0;
	logic [15:0] sib = 16'h0000;
	logic [3:0] mode = 4'h0;
	logic [15:0] cmp = 16'h0010;
	logic cmp_en = 1'b0;
	logic force_trig = 1'b0;
	logic ce = 1'b1;
	sbt_pins_in_t pins_in = '0;
	logic [7:0] reg_rdata;
	logic trig;
	logic [15:0] tbase;
	logic tb_this;
	sbt_pins_out_t pins_out;
	logic irq;
	logic [31:0] seed = 32'h8b1c63d9;
	logic [7:0] rv;
	logic [15:0] v;
	logic [15:0] w;
	logic [15:0] maxc;
	int num_errors = 0;
	int checks_done = 0;

	always #12.5 clk = ~clk;

	sbt_timer u_sbt_timer (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_pin(ext_pin), .osc_clk(osc_clk),
		.secondary_osc_enable(osc_en), .sibling_count(sib), .capture_compare_mode_field(mode),
		.special_event_trigger(trig), .ccp_timebase(tbase), .ccp_timebase_is_this(tb_this),
		.pins_in(pins_in), .pins_out(pins_out), .irq(irq));
	sbt_ccp_model u_sbt_ccp_model (.clk(clk), .rst_n(rst_n), .compare_value_pair(cmp), .match_enable(cmp_en),
		.force_trigger(force_trig), .timebase(tbase), .timebase_is_this(tb_this), .special_event_trigger(trig));

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] ps_expect(input int code, input int cycles);
		return 16'((cycles / SBT_INSTR_DIV) >> code);
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task automatic rd_cnt(output logic [15:0] c);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(SBT_OFS_LOW, lo);
		rd(SBT_OFS_HIGH, hi);
		c = {hi, lo};
	endtask
	task automatic ld_cnt(input logic [15:0] c);
		wr(SBT_OFS_HIGH, c[15:8]);
		wr(SBT_OFS_LOW, c[7:0]);
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g, input int tol);
		checks_done++;
		if ($isunknown(g) || g > e + tol || g + tol < e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	// trigger with or without a low byte write beside it
	task automatic fire(input logic with_wr);
		@(posedge clk);
		reg_addr   <= SBT_OFS_LOW;
		reg_wdata  <= 8'h55;
		reg_wr     <= with_wr;
		force_trig <= 1'b1;
		@(posedge clk);
		reg_wr     <= 1'b0;
		force_trig <= 1'b0;
	endtask
	task automatic pulses(input int n, input logic use_osc);
		repeat (n) begin
			repeat (8) @(posedge clk);
			osc_clk <= use_osc;
			ext_pin <= !use_osc;
			repeat (8) @(posedge clk);
			osc_clk <= 1'b0;
			ext_pin <= 1'b0;
		end
	endtask
	task automatic end_sim;
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(SBT_OFS_CTRL, rv);
		chk("ctrl reset", 16'h0000, {8'h00, rv}, 0);
		wr(3'h7, 8'hff);
		rd(3'h7, rv);
		chk("unmapped", 16'h0000, {8'h00, rv}, 0);
		// random control, sibling, pins
		repeat (12) begin
			seed = lfsr(seed);
			sib     <= seed[31:16];
			osc_en  <= seed[12];
			pins_in <= seed[21:16];
			wr(SBT_OFS_CTRL, seed[7:0]);
			rd(SBT_OFS_CTRL, rv);
			chk("ctrl", {8'h00, seed[7:0] & SBT_CTRL_MASK}, {8'h00, rv}, 0);
			if (!seed[SBT_BIT_TBSEL]) chk("sibling base", seed[31:16], tbase, 0);
			if (seed[12]) chk("osc pins", 16'h0000, {12'h0, pins_out.pin_oe, pins_out.port_read}, 0);
			if (!seed[12]) chk("pin oe", {14'h0, ~seed[21:20]}, {14'h0, pins_out.pin_oe}, 0);
		end
		osc_en <= 1'b0;
		// every prescale code, then hold while stopped
		for (int c = 0; c < 4; c++) begin
			wr(SBT_OFS_CTRL, 8'(c << 4));
			ld_cnt(16'h0000);
			wr(SBT_OFS_CTRL, 8'(c << 4) | 8'h09);
			repeat (256) @(posedge clk);
			wr(SBT_OFS_CTRL, 8'(c << 4));
			rd_cnt(v);
			chk("prescaled", ps_expect(c, 258), v, 1);
			repeat (40) @(posedge clk);
			rd_cnt(w);
			chk("held", v, w, 0);
		end
		// clock enable low freezes a running counter
		ld_cnt(16'h0000);
		wr(SBT_OFS_CTRL, 8'h09);
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		ce <= 1'b1;
		wr(SBT_OFS_CTRL, 8'h08);
		rd_cnt(v);
		chk("frozen by enable", 16'h0000, v, 1);
		// wrap, masked and unmasked interrupt
		wr(SBT_OFS_ENABLES, 8'h00);
		ld_cnt(16'hffff);
		wr(SBT_OFS_CTRL, 8'h01);
		repeat (8) @(posedge clk);
		wr(SBT_OFS_CTRL, 8'h00);
		rd(SBT_OFS_FLAGS, rv);
		chk("overflow flag", 16'h0002, {8'h00, rv}, 0);
		chk("masked irq", 16'h0000, {15'h0, irq}, 0);
		rd_cnt(v);
		chk("wrapped", 16'h0001, v, 1);
		wr(SBT_OFS_ENABLES, 8'h02);
		repeat (2) @(posedge clk);
		chk("irq on", 16'h0001, {15'h0, irq}, 0);
		wr(SBT_OFS_FLAGS, 8'h02);
		repeat (2) @(posedge clk);
		chk("irq off", 16'h0000, {15'h0, irq}, 0);
		// compare pair as period, special event mode only
		mode   <= SBT_MODE_SPEVT;
		cmp_en <= 1'b1;
		ld_cnt(16'h0000);
		wr(SBT_OFS_CTRL, 8'h09);
		repeat (2) @(posedge clk);
		maxc = 16'h0000;
		repeat (400) begin
			@(posedge clk);
			if (tbase > maxc) maxc = tbase;
		end
		chk("period top", cmp, maxc, 0);
		seed = lfsr(seed);
		mode <= (seed[3:0] == SBT_MODE_SPEVT) ? 4'h2 : seed[3:0];
		repeat (200) @(posedge clk);
		chk("other mode runs on", 16'h003a, tbase, 10);
		// write against trigger, trigger alone
		cmp_en <= 1'b0;
		mode   <= SBT_MODE_SPEVT;
		wr(SBT_OFS_CTRL, 8'h08);
		ld_cnt(16'h1200);
		fire(1'b1);
		rd_cnt(v);
		chk("write wins", 16'h1255, v, 0);
		ld_cnt(16'hffff);
		fire(1'b0);
		rd_cnt(v);
		chk("trigger clear", 16'h0000, v, 0);
		rd(SBT_OFS_FLAGS, rv);
		chk("no flag on clear", 16'h0000, {8'h00, rv}, 0);
		// buffered high byte
		wr(SBT_OFS_CTRL, 8'h80);
		wr(SBT_OFS_HIGH, 8'h3c);
		wr(SBT_OFS_CTRL, 8'h00);
		rd(SBT_OFS_HIGH, rv);
		chk("high buffered", 16'h0000, {8'h00, rv}, 0);
		wr(SBT_OFS_CTRL, 8'h80);
		wr(SBT_OFS_LOW, 8'ha5);
		wr(SBT_OFS_CTRL, 8'h00);
		rd_cnt(v);
		chk("atomic load", 16'h3ca5, v, 0);
		// synced pin, bypassed pin, oscillator
		for (int m = 0; m < 3; m++) begin
			osc_en <= (m == 2);
			ld_cnt(16'h0000);
			wr(SBT_OFS_CTRL, (m == 1) ? 8'h07 : 8'h03);
			pulses(10, m == 2);
			repeat (16) @(posedge clk);
			wr(SBT_OFS_CTRL, 8'h00);
			rd_cnt(v);
			chk("external count", 16'h000a, v, 0);
		end
		// low byte write restarts the divide-by-8 prescaler
		osc_en <= 1'b0;
		ld_cnt(16'h0000);
		wr(SBT_OFS_CTRL, 8'h37);
		pulses(5, 1'b0);
		wr(SBT_OFS_LOW, 8'h00);
		pulses(3, 1'b0);
		repeat (8) @(posedge clk);
		wr(SBT_OFS_CTRL, 8'h00);
		rd_cnt(v);
		chk("prescaler restart", 16'h0000, v, 0);
		end_sim;
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim;
	end
endmodule
